/* File: dslc_core.sv */
// security lock state control: gates host commands by lock state
// ****************************************************
// Functional notes
// R1: decode six security opcodes F1h to F6h
// R2: abort security commands once storage security active
// R3: user password set means locked after power-on
// R4: locked leaves only by good unlock or erase
// R5: unlocked accepts all; entered at power-on without password
// R6: frozen rejects lock and password changing commands
// R7: freeze lock holds frozen until power removed
// R8: high level lets master password unlock
// R9: maximum level: master unlocks only via erase unit
// R10: master password never enables lock
// R11: report master revision code, 0001h to FFFEh
// R12: user password locks at next reset only
// R13: five mismatches set exhausted flag, abort unlock/erase
// R14: rejected commands abort, state unchanged
// ****************************************************
`timescale 1ns/100ps
`default_nettype none
`include "dslc_defines.svh"

module dslc_core
    import dslc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // power-on (true) vs hard reset qualifier, one-cycle pulse
    input  wire logic        hard_reset_in,
    input  wire logic        power_on_in,
    // storage-security feature set activated
    input  wire logic        ext_sec_active_in,
    // command request
    input  wire logic        cmd_valid_in,
    input  wire dslc_cmd_s   cmd_in,
    // identify word read
    input  wire logic [7:0]  id_word_sel_in,
    // completion
    output logic             resp_valid_out,
    output dslc_resp_s       resp_out,
    // status
    output dslc_state_e      state_out,
    output logic             user_pw_set_out,
    output logic             unlock_attempts_exhausted_flag_out,
    output logic [15:0]      id_word_out
);

    // ****************************************************
    // state
    // ****************************************************
    dslc_state_e state_ff,      nxt_state;
    logic        user_pw_ff,    nxt_user_pw;
    logic        level_max_ff,  nxt_level_max;
    logic [15:0] rev_ff,        nxt_rev;
    logic [2:0]  miss_ff,       nxt_miss;
    logic        resp_v_ff,     nxt_resp_v;
    dslc_resp_s  resp_ff,       nxt_resp;
    logic [15:0] id_ff,         nxt_id;

    logic exhausted;
    logic sec_op;

    function automatic logic is_sec_op(input logic [7:0] op);
        is_sec_op = (op >= `DSLC_OP_SET_PW) && (op <= `DSLC_OP_DISABLE_PW); // R1
    endfunction

    assign exhausted = (miss_ff >= `DSLC_MISMATCH_LIMIT);
    assign sec_op    = is_sec_op(cmd_in.opcode);

    // ****************************************************
    // next state
    // ****************************************************
    always_comb
    begin
        nxt_state     = state_ff;
        nxt_user_pw   = user_pw_ff;
        nxt_level_max = level_max_ff;
        nxt_rev       = rev_ff;
        nxt_miss      = miss_ff;
        nxt_resp_v    = 1'b0;
        nxt_resp      = '0;
        if (hard_reset_in)
        begin
            nxt_miss = 3'h0; // R13
            // frozen survives hard reset; only power-on leaves it
            if (state_ff != DSLC_FROZEN || power_on_in) // R7
            begin
                nxt_state = user_pw_ff ? DSLC_LOCKED : DSLC_UNLOCKED; // R3 R5 R12
            end
        end
        else if (cmd_valid_in)
        begin
            nxt_resp_v       = 1'b1;
            nxt_resp.execute = 1'b1;
            if (sec_op && ext_sec_active_in)
            begin
                nxt_resp.execute = 1'b0; // R2 R14
            end
            else if (!sec_op)
            begin
                if (state_ff == DSLC_LOCKED && cmd_in.is_media)
                begin
                    nxt_resp.execute = 1'b0; // R3 R14
                end
            end
            else
            begin
                case (cmd_in.opcode)
                    `DSLC_OP_SET_PW:
                    begin
                        if (state_ff != DSLC_UNLOCKED) nxt_resp.execute = 1'b0; // R6
                        else if (cmd_in.pw_master)
                        begin
                            // master change only records its revision
                            if (cmd_in.master_rev >= `DSLC_REV_MIN && cmd_in.master_rev <= `DSLC_REV_MAX)
                                nxt_rev = cmd_in.master_rev; // R10 R11
                        end
                        else
                        begin
                            nxt_user_pw   = 1'b1; // R12
                            nxt_level_max = cmd_in.level_max;
                        end
                    end
                    `DSLC_OP_UNLOCK:
                    begin
                        if (state_ff == DSLC_FROZEN || exhausted) nxt_resp.execute = 1'b0; // R6 R13
                        else if (!cmd_in.pw_match)
                        begin
                            nxt_resp.execute = 1'b0;
                            nxt_miss         = miss_ff + 3'h1; // R13
                        end
                        else if (cmd_in.pw_master && level_max_ff && state_ff == DSLC_LOCKED)
                            nxt_resp.execute = 1'b0; // R9
                        else
                            nxt_state = DSLC_UNLOCKED; // R4 R8
                    end
                    `DSLC_OP_ERASE_PREP:
                        if (state_ff == DSLC_FROZEN) nxt_resp.execute = 1'b0; // R6
                    `DSLC_OP_ERASE_UNIT:
                    begin
                        if (state_ff == DSLC_FROZEN || exhausted) nxt_resp.execute = 1'b0; // R6 R13
                        else if (!cmd_in.pw_match)
                        begin
                            nxt_resp.execute = 1'b0;
                            nxt_miss         = miss_ff + 3'h1; // R13
                        end
                        else
                        begin
                            nxt_resp.erase_data = 1'b1; // R9
                            nxt_user_pw         = 1'b0;
                            nxt_state           = DSLC_UNLOCKED; // R4
                        end
                    end
                    `DSLC_OP_FREEZE:
                        if (state_ff == DSLC_LOCKED) nxt_resp.execute = 1'b0;
                        else nxt_state = DSLC_FROZEN; // R7
                    default:
                    begin
                        // disable password
                        if (state_ff != DSLC_UNLOCKED || !cmd_in.pw_match) nxt_resp.execute = 1'b0; // R6
                        else nxt_user_pw = 1'b0;
                    end
                endcase
            end
            nxt_resp.abort = !nxt_resp.execute; // R14
        end
    end

    // identify words
    always_comb
    begin
        nxt_id = 16'h0000;
        if (id_word_sel_in == `DSLC_ID_WORD_REV)
            nxt_id = rev_ff; // R11
        else if (id_word_sel_in == `DSLC_ID_WORD_SEC)
            nxt_id[`DSLC_UNLOCK_ATTEMPTS_EXHAUSTED_FLAG_BIT] = exhausted; // R13
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            state_ff     <= DSLC_UNLOCKED;
            user_pw_ff   <= 1'b0;
            level_max_ff <= 1'b0;
            rev_ff       <= `DSLC_REV_RESET;
            miss_ff      <= 3'h0;
            resp_v_ff    <= 1'b0;
            resp_ff      <= '0;
            id_ff        <= 16'h0000;
        end
        else
        begin
            state_ff     <= nxt_state;
            user_pw_ff   <= nxt_user_pw;
            level_max_ff <= nxt_level_max;
            rev_ff       <= nxt_rev;
            miss_ff      <= nxt_miss;
            resp_v_ff    <= nxt_resp_v;
            resp_ff      <= nxt_resp;
            id_ff        <= nxt_id;
        end
    end

    assign resp_valid_out                     = resp_v_ff;
    assign resp_out                           = resp_ff;
    assign state_out                          = state_ff;
    assign user_pw_set_out                    = user_pw_ff;
    assign unlock_attempts_exhausted_flag_out = exhausted;
    assign id_word_out                        = id_ff;

endmodule
`default_nettype wire

/* File: dslc_defines.svh */
// constants for the drive security lock control block
`ifndef DSLC_DEFINES_SVH
`define DSLC_DEFINES_SVH

// ****************************************************
// security command opcodes
// ****************************************************
`define DSLC_OP_SET_PW          8'hF1
`define DSLC_OP_UNLOCK          8'hF2
`define DSLC_OP_ERASE_PREP      8'hF3
`define DSLC_OP_ERASE_UNIT      8'hF4
`define DSLC_OP_FREEZE          8'hF5
`define DSLC_OP_DISABLE_PW      8'hF6

// ****************************************************
// attempt limit, identify words and fields
// ****************************************************
`define DSLC_MISMATCH_LIMIT     3'h5
`define DSLC_ID_WORD_REV        8'h5C
`define DSLC_ID_WORD_SEC        8'h80
`define DSLC_UNLOCK_ATTEMPTS_EXHAUSTED_FLAG_BIT         4
`define DSLC_REV_MIN            16'h0001
`define DSLC_REV_MAX            16'hFFFE
`define DSLC_REV_RESET          16'hFFFE

`endif

/* File: dslc_pkg.sv */
// types for the drive security lock control block
package dslc_pkg;

    typedef enum logic [1:0]
    {
        DSLC_UNLOCKED = 2'b00,
        DSLC_LOCKED   = 2'b01,
        DSLC_FROZEN   = 2'b10
    } dslc_state_e;

    // one command from the host-side command layer
    typedef struct packed
    {
        logic [7:0]  opcode;
        logic        is_media;
        logic        pw_master;
        logic        pw_match;
        logic        level_max;
        logic [15:0] master_rev;
    } dslc_cmd_s;

    // completion back to the command layer
    typedef struct packed
    {
        logic        execute;
        logic        abort;
        logic        erase_data;
    } dslc_resp_s;

endpackage

/* File: dslc_host.sv */
// host-side command source feeding the lock control
`timescale 1ns/100ps
`default_nettype none
module dslc_host
    import dslc_pkg::*;
(
    // request from the bench
    input  wire logic      go_in,
    input  wire dslc_cmd_s req_in,
    // toward the block
    output logic           cmd_valid_out,
    output dslc_cmd_s      cmd_out
);
    // no extra stage, so the response stays one cycle after the request
    assign cmd_valid_out = go_in;
    assign cmd_out       = req_in;
endmodule
`default_nettype wire

/* File: dslc_props.sv */
// assertions on the lock control ports
`timescale 1ns/100ps
`default_nettype none
`include "dslc_defines.svh"
module dslc_props
    import dslc_pkg::*;
(
    // clock and reset
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    // block inputs
    input wire logic        hard_reset_in,
    input wire logic        power_on_in,
    input wire logic        ext_sec_active_in,
    input wire logic        cmd_valid_in,
    input wire dslc_cmd_s   cmd_in,
    input wire logic [7:0]  id_word_sel_in,
    // block outputs
    input wire logic        resp_valid_out,
    input wire dslc_resp_s  resp_out,
    input wire dslc_state_e state_out,
    input wire logic        user_pw_set_out,
    input wire logic        unlock_attempts_exhausted_flag_out,
    input wire logic [15:0] id_word_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // a hard reset in the same cycle drops the command
    wire logic       tk = cmd_valid_in && !hard_reset_in;
    wire logic [7:0] op = cmd_in.opcode;
    wire logic       sc = op >= `DSLC_OP_SET_PW && op <= `DSLC_OP_DISABLE_PW;
    a_resp_follows: assert property (tk |=> resp_valid_out) else $error("no response");
    a_resp_cause: assert property (resp_valid_out |-> $past(tk)) else $error("stray response");
    a_abort_keeps: assert property (resp_valid_out && resp_out.abort |->
        !resp_out.execute && state_out == $past(state_out)) else $error("abort moved state");
    a_sec_active: assert property (tk && sc && ext_sec_active_in |=> resp_out.abort) else $error("not aborted");
    a_locked_media: assert property (tk && cmd_in.is_media && state_out == DSLC_LOCKED |=> resp_out.abort)
        else $error("media ran locked");
    a_unlocked_all: assert property (tk && !sc && state_out == DSLC_UNLOCKED |=> resp_out.execute)
        else $error("unlocked refused");
    a_frozen_pw: assert property (tk && sc && op != `DSLC_OP_FREEZE && state_out == DSLC_FROZEN |=>
        resp_out.abort) else $error("frozen ran lock cmd");
    a_frozen_holds: assert property (state_out == DSLC_FROZEN && !(hard_reset_in && power_on_in) |=>
        state_out == DSLC_FROZEN) else $error("left frozen");
    a_tries_out: assert property (tk && unlock_attempts_exhausted_flag_out &&
        (op == `DSLC_OP_UNLOCK || op == `DSLC_OP_ERASE_UNIT) |=> resp_out.abort) else $error("tries not limited");
    a_lock_late: assert property ($rose(user_pw_set_out) |-> state_out != DSLC_LOCKED) else $error("locked early");
    a_no_pw_open: assert property (hard_reset_in && !user_pw_set_out && state_out != DSLC_FROZEN |=>
        state_out == DSLC_UNLOCKED) else $error("locked without user password");
endmodule
bind dslc_core dslc_props props_u(.clk_in, .reset_n_in, .hard_reset_in, .power_on_in, .ext_sec_active_in,
    .cmd_valid_in, .cmd_in, .id_word_sel_in, .resp_valid_out, .resp_out, .state_out, .user_pw_set_out,
    .unlock_attempts_exhausted_flag_out, .id_word_out);
`default_nettype wire

/* File: tb_drive_security_lock_control.sv */
// self-checking bench for the drive security lock control
`timescale 1ns/100ps
`default_nettype none
`include "dslc_defines.svh"
module tb_drive_security_lock_control
    import dslc_pkg::*;
;
    logic        clk_in = '0, reset_n_in = '0, hard_reset_in = '0, power_on_in = '0, ext_sec_active_in = '0, go = '0;
    logic [7:0]  id_word_sel_in = 8'h00;
    dslc_cmd_s   req = '0, cmd_in;
    logic        cmd_valid_in, resp_valid_out, user_pw_set_out, unlock_attempts_exhausted_flag_out;
    dslc_resp_s  resp_out;
    dslc_state_e state_out;
    logic [15:0] id_word_out;
    int          fail_count = 0, cmp_count = 0, cyc = 0;
    always #25 clk_in = ~clk_in;
    dslc_host host_u(.go_in(go), .req_in(req), .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in));
    dslc_core dut_u(.clk_in, .reset_n_in, .hard_reset_in, .power_on_in, .ext_sec_active_in, .cmd_valid_in, .cmd_in,
        .id_word_sel_in, .resp_valid_out, .resp_out, .state_out, .user_pw_set_out,
        .unlock_attempts_exhausted_flag_out, .id_word_out);
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    begin
        cmp_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("FAIL %s exp %h seen %h", n, e, s);
        end
    end
    endtask
    // f = is_media, pw_master, pw_match, level_max
    task cm(input logic [7:0] op, input logic [3:0] f, input logic ex, input logic [15:0] rev = 16'h0000);
    begin
        @(posedge clk_in);
        go  <= 1'b1;
        req <= {op, f, rev};
        @(posedge clk_in);
        go  <= 1'b0;
        @(negedge clk_in);
        chk("resp_valid", 16'(resp_valid_out), 16'h0001);
        chk("execute", 16'(resp_out.execute), 16'(ex));
        chk("abort", 16'(resp_out.abort), 16'(!ex));
    end
    endtask
    task hrst(input logic p, input dslc_state_e e);
    begin
        @(posedge clk_in);
        hard_reset_in <= 1'b1;
        power_on_in   <= p;
        @(posedge clk_in);
        hard_reset_in <= 1'b0;
        power_on_in   <= 1'b0;
        @(negedge clk_in);
        chk("state", 16'(state_out), 16'(e));
    end
    endtask
    task idw(input logic [7:0] w, input logic [15:0] e);
    begin
        @(posedge clk_in);
        id_word_sel_in <= w;
        @(posedge clk_in);
        @(negedge clk_in);
        chk("id_word", id_word_out, e);
    end
    endtask
    task t_master;
    begin
        cm(8'hC8, 4'b1000, 1'b1);
        idw(`DSLC_ID_WORD_REV, 16'hFFFE);
        cm(`DSLC_OP_SET_PW, 4'b0110, 1'b1, 16'h1234);
        idw(`DSLC_ID_WORD_REV, 16'h1234);
        cm(`DSLC_OP_SET_PW, 4'b0110, 1'b1, 16'hFFFF);
        idw(`DSLC_ID_WORD_REV, 16'h1234);
        hrst(1'b1, DSLC_UNLOCKED);
    end
    endtask
    task t_user;
    begin
        cm(`DSLC_OP_SET_PW, 4'b0010, 1'b1);
        chk("user_pw", 16'(user_pw_set_out), 16'h0001);
        chk("state", 16'(state_out), 16'(DSLC_UNLOCKED));
        hrst(1'b0, DSLC_LOCKED);
        cm(8'hC8, 4'b1000, 1'b0);
        cm(`DSLC_OP_SET_PW, 4'b0010, 1'b0);
        cm(`DSLC_OP_UNLOCK, 4'b0110, 1'b1);
        chk("state", 16'(state_out), 16'(DSLC_UNLOCKED));
    end
    endtask
    task t_tries;
    begin
        hrst(1'b0, DSLC_LOCKED);
        repeat (5) cm(`DSLC_OP_UNLOCK, 4'b0000, 1'b0);
        chk("exhausted", 16'(unlock_attempts_exhausted_flag_out), 16'h0001);
        idw(`DSLC_ID_WORD_SEC, 16'h0010);
        cm(`DSLC_OP_UNLOCK, 4'b0010, 1'b0);
        hrst(1'b0, DSLC_LOCKED);
        chk("exhausted", 16'(unlock_attempts_exhausted_flag_out), 16'h0000);
        cm(`DSLC_OP_UNLOCK, 4'b0010, 1'b1);
        cm(`DSLC_OP_DISABLE_PW, 4'b0010, 1'b1);
        chk("user_pw", 16'(user_pw_set_out), 16'h0000);
    end
    endtask
    task t_max;
    begin
        cm(`DSLC_OP_SET_PW, 4'b0011, 1'b1);
        hrst(1'b0, DSLC_LOCKED);
        cm(`DSLC_OP_UNLOCK, 4'b0110, 1'b0);
        cm(`DSLC_OP_ERASE_PREP, 4'b0110, 1'b1);
        cm(`DSLC_OP_ERASE_UNIT, 4'b0110, 1'b1);
        chk("erase", 16'(resp_out.erase_data), 16'h0001);
        chk("user_pw", 16'(user_pw_set_out), 16'h0000);
        chk("state", 16'(state_out), 16'(DSLC_UNLOCKED));
    end
    endtask
    task t_freeze;
    begin
        cm(`DSLC_OP_FREEZE, 4'b0000, 1'b1);
        cm(`DSLC_OP_SET_PW, 4'b0010, 1'b0);
        cm(`DSLC_OP_DISABLE_PW, 4'b0010, 1'b0);
        cm(8'hC8, 4'b1000, 1'b1);
        hrst(1'b0, DSLC_FROZEN);
        hrst(1'b1, DSLC_UNLOCKED);
    end
    endtask
    // activated storage security refuses all six codes
    task t_sec;
    begin
        @(posedge clk_in);
        ext_sec_active_in <= 1'b1;
        for (int i = 1; i < 7; i++) cm(8'hF0 + 8'(i), 4'b0010, 1'b0);
        @(posedge clk_in);
        ext_sec_active_in <= 1'b0;
    end
    endtask
    task tally_and_finish;
    begin
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    // ceiling well above the fewer than a hundred cycles the run needs
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_master;
        t_user;
        t_tries;
        t_max;
        t_freeze;
        t_sec;
        tally_and_finish;
    end
endmodule
`default_nettype wire
